// [inc/cpw_consts.vh]
// Constants of the complementary three-phase PWM generator.
// Assumes a 40 MHz core clock and an APB master with 32-bit data.
`ifndef CPW_CONSTS_VH
`define CPW_CONSTS_VH

// Timing
`define CPW_CORE_PS      25000
`define CPW_MAIN_MHZ     160
`define CPW_SKIP_DIV     2
`define CPW_TICK_PS      (1000000 * `CPW_SKIP_DIV / `CPW_MAIN_MHZ)
`define CPW_CARRIER_NS   125000
`define CPW_DEAD_NS      2500
`define CPW_HALF_TICKS   (`CPW_CARRIER_NS * 1000 / `CPW_TICK_PS / 2)
`define CPW_DEAD_TICKS   (`CPW_DEAD_NS * 1000 / `CPW_TICK_PS)
`define CPW_STEP         (`CPW_CORE_PS / `CPW_TICK_PS)

// Reset values
`define CPW_PER_RST      16'h1388
`define CPW_DUTY_RST     16'h09A4
`define CPW_DEAD_RST     16'h00C8
`define CPW_SL_RST       4'hF
`define CPW_RTE_DT_RST   16'h0000

// Register offsets
`define CPW_A_CTRL       8'h00
`define CPW_A_RELOAD     8'h04
`define CPW_A_INTTRIG    8'h08
`define CPW_A_IRQ_STAT   8'h0C
`define CPW_A_IRQ_MASK   8'h10
`define CPW_A_DEAD       8'h14
`define CPW_A_STATUS     8'h18
`define CPW_A_SLCS       8'h1C
`define CPW_A_SHADOW     8'h20
`define CPW_A_SHADOW_END 8'h3C

// Control fields
`define CPW_C_RUN        0
`define CPW_C_OUTEN      1
`define CPW_C_VALLEY     2
`define CPW_C_FUPD       3

`endif

// [design/cpw_shadow_mem.v]
// Shadow compare store: period and duty shadows of four channels.
// Word 2k is channel k period shadow, word 2k+1 its duty shadow.
`default_nettype none
`include "cpw_consts.vh"

module cpw_shadow_mem (
  // Clock and reset
  input  wire         i_core_clk,
  input  wire         i_rst_n,
  // Write port
  input  wire         i_we,
  input  wire [2:0]   i_waddr,
  input  wire [15:0]  i_wdata,
  // Registered view of all words
  output reg  [127:0] o_all
);

  reg [15:0] mem_r [0:7];
  integer    k;
  integer    j;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (k = 0; k < 8; k = k + 1) begin
        mem_r[k] <= (k % 2 == 0) ? `CPW_PER_RST : `CPW_DUTY_RST;
      end
    end else if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  // Read data registered; one cycle behind a write
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_all <= {4{`CPW_DUTY_RST, `CPW_PER_RST}};
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        o_all[j*16 +: 16] <= mem_r[j];
      end
    end
  end

endmodule // cpw_shadow_mem

`default_nettype wire

// [design/cpw_top.v]
// Complementary three-phase PWM generator with APB register access.
// Assumes APB master synchronous to i_core_clk; outputs feed gate drivers.
//
// Function
// - Carrier period is 125 us, 8 kHz, on every phase.
// - High and low side of a phase separated by 2.5 us dead time with level set; with level clear both sides overlap for 2.5 us.
// - Counter steps by two ticks (one with clock source set) up and down; period compare 0x1388.
// - Reference duty compare is just under half the period compare, 0x09A4, active and shadow.
// - Valley of the counter raises the cycle interrupt.
// - Shadow to active reload at valley when enabled, or on forced update.
// - New duty written after interrupt applies at next reload point.
// - Each channel positive output starts high before first compare match.
// - Reference period compare match acts as the counter turn trigger.
// - Reference channel drives chain trigger keeping followers in step.
// - Per-channel reload enables cover period, duty, level, clock source.
// - Forced update loads all four counters at once.
// - Output drive enable separate from counter run enable.
// - Each channel may contribute an interrupt trigger.
// - Routing passes primary PWM unchanged to positive output.
// - Routing inverts complement input onto negative output.
`default_nettype none
`include "cpw_consts.vh"

module cpw_top (
  // Clock and reset
  input  wire        i_core_clk,
  input  wire        i_rst_n,
  // APB slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  // PWM outputs
  output reg  [3:0]  o_routing_positive_out,
  output reg  [3:0]  o_routing_negative_out,
  output reg         o_chain_trigger_out,
  // Interrupt
  output reg         o_valley_cycle_irq
);

  localparam integer STEP_INT = `CPW_STEP;
  localparam [15:0]  STEP     = STEP_INT[15:0];

  // Level while counter below compare, else its inverse
  function cmp_lvl;
    input [15:0] cnt;
    input [15:0] cmp;
    input        sl;
    begin
      cmp_lvl = (cnt < cmp) ? sl : ~sl;
    end
  endfunction

  // Software registers
  reg  [2:0]   ctrl_r;
  reg  [3:0]   reload_en_r;
  reg  [3:0]   int_trig_r;
  reg  [3:0]   irq_stat_r;
  reg  [3:0]   irq_mask_r;
  reg  [15:0]  dead_r;
  reg  [3:0]   sl_shd_r;
  reg  [3:0]   cs_shd_r;
  // Channel state
  reg  [15:0]  cnt_r   [0:3];
  reg  [15:0]  cm0_r   [0:3];
  reg  [15:0]  cm1_r   [0:3];
  reg  [3:0]   down_r;
  reg  [3:0]   sl_r;
  reg  [3:0]   cs_r;
  reg          fupd_r;
  reg  [3:0]   valley_nxt;
  reg  [15:0]  cnt_nxt [0:3];
  reg  [3:0]   down_nxt;
  reg  [3:0]   pri_nxt;
  reg  [3:0]   cmp_in_nxt;
  reg  [15:0]  step;
  reg  [16:0]  dcmp;
  reg  [31:0]  rd_nxt;
  reg          err_nxt;
  wire [127:0] shd_all;
  wire         setup;
  wire         wr_acc;
  wire         shd_hit;
  wire [3:0]   w1c;
  wire [3:0]   trig;
  integer      c;
  integer      rc;
  integer      pc;

  assign setup   = i_psel & ~i_penable;
  assign wr_acc  = i_psel & i_penable & o_pready & i_pwrite;
  assign shd_hit = (i_paddr >= `CPW_A_SHADOW) && (i_paddr <= `CPW_A_SHADOW_END);
  assign w1c     = (wr_acc && i_paddr == `CPW_A_IRQ_STAT) ? i_pwdata[3:0] : 4'h0;

  cpw_shadow_mem u_shadow (
    .i_core_clk (i_core_clk),
    .i_rst_n    (i_rst_n),
    .i_we       (wr_acc && shd_hit && (i_paddr[1:0] == 2'b00)),
    .i_waddr    (i_paddr[4:2]),
    .i_wdata    (i_pwdata[15:0]),
    .o_all      (shd_all)
  );

  // Read mux and decode, latched in the setup cycle
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (i_paddr[1:0] != 2'b00) begin
      err_nxt = 1'b1;
    end else if (i_paddr == `CPW_A_CTRL) begin
      rd_nxt[2:0] = ctrl_r;
    end else if (i_paddr == `CPW_A_RELOAD) begin
      rd_nxt[3:0] = reload_en_r;
    end else if (i_paddr == `CPW_A_INTTRIG) begin
      rd_nxt[3:0] = int_trig_r;
    end else if (i_paddr == `CPW_A_IRQ_STAT) begin
      rd_nxt[3:0] = irq_stat_r;
    end else if (i_paddr == `CPW_A_IRQ_MASK) begin
      rd_nxt[3:0] = irq_mask_r;
    end else if (i_paddr == `CPW_A_DEAD) begin
      rd_nxt[15:0] = dead_r;
    end else if (i_paddr == `CPW_A_STATUS) begin
      rd_nxt = {12'h000, down_r, cnt_r[0]};
    end else if (i_paddr == `CPW_A_SLCS) begin
      rd_nxt = {16'h0000, sl_r, cs_r, cs_shd_r, sl_shd_r};
    end else if (shd_hit) begin
      rd_nxt[15:0] = shd_all[i_paddr[4:2]*16 +: 16];
    end else begin
      err_nxt = 1'b1;
    end
  end

  // No wait state: ready rises in the first access cycle
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup & err_nxt;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_nxt;
      end
    end
  end

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r      <= 3'h0;
      reload_en_r <= 4'h0;
      int_trig_r  <= 4'h0;
      irq_mask_r  <= 4'h0;
      dead_r      <= `CPW_DEAD_RST;
      sl_shd_r    <= `CPW_SL_RST;
      cs_shd_r    <= 4'h0;
      fupd_r      <= 1'b0;
    end else begin
      // Force update is a self-clearing strobe
      fupd_r <= wr_acc && (i_paddr == `CPW_A_CTRL) && i_pwdata[`CPW_C_FUPD];
      if (wr_acc) begin
        if (i_paddr == `CPW_A_CTRL) begin
          ctrl_r <= i_pwdata[2:0];
        end else if (i_paddr == `CPW_A_RELOAD) begin
          reload_en_r <= i_pwdata[3:0];
        end else if (i_paddr == `CPW_A_INTTRIG) begin
          int_trig_r <= i_pwdata[3:0];
        end else if (i_paddr == `CPW_A_IRQ_MASK) begin
          irq_mask_r <= i_pwdata[3:0];
        end else if (i_paddr == `CPW_A_DEAD) begin
          dead_r <= i_pwdata[15:0];
        end else if (i_paddr == `CPW_A_SLCS) begin
          sl_shd_r <= i_pwdata[3:0];
          cs_shd_r <= i_pwdata[7:4];
        end
      end
    end
  end

  // Counter next state, one step per core clock
  always @* begin
    valley_nxt = 4'h0;
    down_nxt   = down_r;
    step       = STEP;
    for (c = 0; c < 4; c = c + 1) begin
      cnt_nxt[c] = cnt_r[c];
      step = cs_r[c] ? 16'h0001 : STEP;
      if (fupd_r) begin
        cnt_nxt[c]  = 16'h0000;
        down_nxt[c] = 1'b0;
      end else if (c != 0 && valley_nxt[0]) begin
        // Followers restart on chain trigger, sharing its valley
        cnt_nxt[c]    = 16'h0000;
        down_nxt[c]   = 1'b0;
        valley_nxt[c] = 1'b1;
      end else if (ctrl_r[`CPW_C_RUN]) begin
        if (!down_r[c]) begin
          if (cnt_r[c] + step >= cm0_r[c]) begin
            cnt_nxt[c]  = cm0_r[c];
            down_nxt[c] = 1'b1;
          end else begin
            cnt_nxt[c] = cnt_r[c] + step;
          end
        end else if (cnt_r[c] <= step) begin
          cnt_nxt[c]    = 16'h0000;
          down_nxt[c]   = 1'b0;
          valley_nxt[c] = 1'b1;
        end else begin
          cnt_nxt[c] = cnt_r[c] - step;
        end
      end
    end
  end

  assign trig = valley_nxt;

  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      down_r <= 4'h0;
      sl_r   <= `CPW_SL_RST;
      cs_r   <= 4'h0;
      for (rc = 0; rc < 4; rc = rc + 1) begin
        cnt_r[rc] <= 16'h0000;
        cm0_r[rc] <= `CPW_PER_RST;
        cm1_r[rc] <= `CPW_DUTY_RST;
      end
    end else begin
      down_r <= down_nxt;
      for (rc = 0; rc < 4; rc = rc + 1) begin
        cnt_r[rc] <= cnt_nxt[rc];
        if (fupd_r || (valley_nxt[rc] && ctrl_r[`CPW_C_VALLEY] && reload_en_r[rc])) begin
          cm0_r[rc] <= shd_all[rc*32 +: 16];
          cm1_r[rc] <= shd_all[rc*32+16 +: 16];
          sl_r[rc]  <= sl_shd_r[rc];
          cs_r[rc]  <= cs_shd_r[rc];
        end
      end
    end
  end

  // Compare stage: primary and widened complement
  always @* begin
    pri_nxt    = 4'h0;
    cmp_in_nxt = 4'h0;
    dcmp       = 17'h00000;
    for (pc = 0; pc < 4; pc = pc + 1) begin
      pri_nxt[pc] = cmp_lvl(cnt_r[pc], cm1_r[pc], sl_r[pc]);
      dcmp = {1'b0, cm1_r[pc]} + {1'b0, dead_r};
      cmp_in_nxt[pc] = dcmp[16] ? sl_r[pc]
                                : cmp_lvl(cnt_r[pc], dcmp[15:0], sl_r[pc]);
    end
  end

  // Routing stage, no own dead time
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_routing_positive_out <= 4'h0;
      o_routing_negative_out <= 4'h0;
    end else if (ctrl_r[`CPW_C_OUTEN]) begin
      o_routing_positive_out <= pri_nxt;
      o_routing_negative_out <= ~cmp_in_nxt;
    end else begin
      o_routing_positive_out <= 4'h0;
      o_routing_negative_out <= 4'h0;
    end
  end

  // Sticky flags; a new event beats a same-cycle clear
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r          <= 4'h0;
      o_valley_cycle_irq  <= 1'b0;
      o_chain_trigger_out <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~w1c) | (valley_nxt & int_trig_r);
      o_valley_cycle_irq  <= |(irq_stat_r & irq_mask_r);
      o_chain_trigger_out <= trig[0];
    end
  end

endmodule // cpw_top

`default_nettype wire

// [test/cpw_gate_drv.sv]
// Gate driver model standing on the generator's high and low side pins.
// Assumes the core clock and async active-low reset of the generator.
`default_nettype none
module cpw_gate_drv (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  // Bridge legs
  input  wire logic [3:0] i_high_side,
  input  wire logic [3:0] i_low_side,
  output var  logic       o_fault
);
  timeunit 1ns;
  timeprecision 1ps;
  // shoot-through watch
  // Latched: one cycle of overlap already destroys a leg
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_fault <= 1'b0;
    else if ((i_high_side & i_low_side) != 4'h0)
      o_fault <= 1'b1;
  end
endmodule // cpw_gate_drv
`default_nettype wire

// [test/cpw_top_properties.sv]
// Port checker of the PWM generator: APB answer, carrier, dead gap, irq.
// Assumes one core clock and the async active-low reset of cpw_top.
`default_nettype none
module cpw_chk (
  // Clock and reset
  input wire logic        i_core_clk,
  input wire logic        i_rst_n,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  // PWM and interrupt
  input wire logic [3:0]  o_routing_positive_out,
  input wire logic [3:0]  o_routing_negative_out,
  input wire logic        o_chain_trigger_out,
  input wire logic        o_valley_cycle_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] per_r;
  logic [15:0] gap_r;
  logic        seen_r;
  logic        armed_r;
  wire logic   both_lo = !o_routing_positive_out[0] && !o_routing_negative_out[0];
  wire logic   wr      = i_psel && i_penable && i_pwrite;
  // Gap only judged once a leg has fallen, not at start-up
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      per_r   <= 16'h0000;
      gap_r   <= 16'h0000;
      seen_r  <= 1'b0;
      armed_r <= 1'b0;
    end else begin
      per_r   <= o_chain_trigger_out ? 16'h0000 : per_r + 16'h0001;
      seen_r  <= seen_r | o_chain_trigger_out;
      gap_r   <= both_lo ? gap_r + 16'h0001 : 16'h0000;
      armed_r <= armed_r | $fell(o_routing_positive_out[0]) | $fell(o_routing_negative_out[0]);
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_no_overlap: assert property ((o_routing_positive_out & o_routing_negative_out) == 4'h0)
    else $error("both sides on");
  a_ready_pulse: assert property (i_psel && !i_penable |=> o_pready)
    else $error("no ready");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("long ready");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("stray error");
  a_chain_single: assert property (o_chain_trigger_out |=> !o_chain_trigger_out [*8])
    else $error("long chain pulse");
  a_chain_period: assert property (o_chain_trigger_out && seen_r |-> per_r == 16'h1387)
    else $error("carrier period wrong");
  a_dead_gap: assert property (armed_r && ($rose(o_routing_negative_out[0]) ||
    $rose(o_routing_positive_out[0])) |-> gap_r == 16'h0064)
    else $error("dead gap wrong");
  a_irq_cause: assert property ($rose(o_valley_cycle_irq) |-> o_chain_trigger_out ||
    $past(o_chain_trigger_out) || $past(o_chain_trigger_out, 2) ||
    $past(o_chain_trigger_out, 3) || $past(wr) || $past(wr, 2) || $past(wr, 3))
    else $error("irq without cause");
  c_chain: cover property (o_chain_trigger_out);
  c_irq: cover property ($rose(o_valley_cycle_irq));
  c_refuse: cover property (o_pslverr);
endmodule // cpw_chk
bind cpw_top cpw_chk i_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr),
  .o_routing_positive_out(o_routing_positive_out),
  .o_routing_negative_out(o_routing_negative_out),
  .o_chain_trigger_out(o_chain_trigger_out), .o_valley_cycle_irq(o_valley_cycle_irq));
`default_nettype wire

// [test/complementary_three_phase_pwm_tb_top.sv]
// Top bench of the PWM generator: registers, carrier widths, reload, irq.
// Assumes the design, the checker and the gate driver model are compiled first.
`default_nettype none
`include "cpw_consts.vh"
module complementary_three_phase_pwm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 2 * `CPW_HALF_TICKS / `CPW_STEP;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        pen = 1'b0;
  logic        pwr = 1'b0;
  logic [7:0]  padr = 8'h00;
  logic [31:0] pwd = 32'h00000000;
  logic [31:0] prd;
  logic        prdy;
  logic        perr;
  logic [3:0]  pos;
  logic [3:0]  neg;
  logic        chain;
  logic        irq;
  logic        fault;
  logic [31:0] rd;
  logic        er;
  logic [15:0] lfsr = 16'h0030;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          hp[4];
  int          hn[4];
  int          duty[4] = '{2468, 5000, 5000, 5000};
  int          old[4];
  logic [7:0]  ra[6] = '{8'h00, 8'h14, 8'h20, 8'h24, 8'h40, 8'h02};
  logic [31:0] rv[6] = '{32'h0, 32'hC8, 32'h1388, 32'h9A4, 32'h0, 32'h0};
  always #12.5 clk = ~clk;
  cpw_top i_dut (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
    .o_routing_positive_out(pos), .o_routing_negative_out(neg),
    .o_chain_trigger_out(chain), .o_valley_cycle_irq(irq));
  cpw_gate_drv i_drv (.i_core_clk(clk), .i_rst_n(rst_n), .i_high_side(pos),
    .i_low_side(neg), .o_fault(fault));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // Waits as long as the slave needs; only the watchdog ends it
    do begin
      @(posedge clk);
    end while (prdy !== 1'b1);
    rd = prd;
    er = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  // Counts clocks of one carrier period with the leg on
  function automatic int legs(int d, bit lo);
    int v;
    legs = 0;
    for (int i = 0; i < N; i++) begin
      v = (i <= N / 2) ? `CPW_STEP * i : `CPW_STEP * (N - i);
      legs += lo ? (v >= d + `CPW_DEAD_TICKS) : (v < d);
    end
  endfunction
  task automatic wait_chain();
    do begin
      @(posedge clk);
    end while (chain !== 1'b1);
  endtask
  task automatic measure(input int d[4]);
    hp = '{0, 0, 0, 0};
    hn = '{0, 0, 0, 0};
    repeat (N) begin
      @(posedge clk);
      for (int k = 0; k < 4; k++) begin
        hp[k] += pos[k];
        hn[k] += neg[k];
      end
    end
    chk(chain, 1'b1);
    for (int k = 0; k < 4; k++) begin
      chk(hp[k], legs(d[k], 1'b0));
      chk(hn[k], legs(d[k], 1'b1));
    end
  endtask
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic new_duty();
    for (int k = 1; k < 4; k++) begin
      lfsr = lfsr_next(lfsr);
      duty[k] = 200 + int'(lfsr % 16'd4600);
      apb(1'b1, 8'(36 + 8 * k), 32'(duty[k]));
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run is about six carrier periods
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ra[k], 32'h0);
      chk(rd, rv[k]);
      chk(er, k > 3);
    end
    chk({pos, neg}, 8'h00);
    apb(1'b1, `CPW_A_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk({pos, neg, chain}, 9'h1E0);
    $display("test registers done");
    new_duty();
    apb(1'b1, `CPW_A_RELOAD, 32'hF);
    apb(1'b1, `CPW_A_INTTRIG, 32'hF);
    apb(1'b1, `CPW_A_IRQ_MASK, 32'h1);
    apb(1'b1, `CPW_A_IRQ_STAT, 32'hF);
    apb(1'b1, `CPW_A_CTRL, 32'hF);
    wait_chain();
    measure(duty);
    chk(irq, 1'b1);
    apb(1'b0, `CPW_A_IRQ_STAT, 32'h0);
    chk(rd, 32'hF);
    apb(1'b1, `CPW_A_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    apb(1'b1, `CPW_A_IRQ_MASK, 32'h1);
    apb(1'b1, `CPW_A_IRQ_STAT, 32'hF);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    $display("test start and irq done");
    old = duty;
    wait_chain();
    fork
      measure(old);
      begin
        repeat (500) @(posedge clk);
        apb(1'b1, `CPW_A_RELOAD, 32'h7);
        new_duty();
      end
    join
    duty[3] = old[3];
    measure(duty);
    chk(fault, 1'b0);
    apb(1'b0, `CPW_A_SLCS, 32'h0);
    chk(rd, 32'h0000F00F);
    apb(1'b1, `CPW_A_SLCS, 32'h8F);
    wait_chain();
    apb(1'b0, `CPW_A_SLCS, 32'h0);
    chk(rd, 32'h0000F08F);
    $display("test reload done");
    complete_run();
  end
endmodule // complementary_three_phase_pwm_tb_top
`default_nettype wire
